// ---- rtl/lbg_pkg.sv ----
// Purpose: Shared constants and types for the local bus glue and bus timer
// Assumes: 125 MHz ref_clk, AHB-Lite register access, 24-bit local address
// Notes: Offsets are byte addresses of one-word registers
package lbg_pkg;
  // ****************************************
  // Local bus map
  // ****************************************
  localparam logic [23:0] ram_last = 24'h03ffff;
  localparam logic [23:0] xram_last = 24'h1fffff;
  localparam logic [23:0] bic_first = 24'h200000;
  localparam logic [23:0] bic_last = 24'h27ffff;
  localparam logic [23:0] glue_first = 24'h280000;
  localparam logic [23:0] glue_last = 24'h2fffff;
  localparam logic [23:0] uart_first = 24'h300000;
  localparam logic [23:0] uart_last = 24'h37ffff;
  localparam logic [23:0] rom_first = 24'h380000;
  localparam logic [23:0] a16_ram_first = 24'h03ff00;
  localparam logic [23:0] ubuf_last = 24'h01ffff;
  localparam logic [23:0] priv_first = 24'h020000;
  localparam logic [23:0] priv_last = 24'h03feff;
  localparam logic [3:0] boot_cycles = 4'h8;
  localparam int jumper_count = 10;
  localparam int vec_w = 5;
  localparam logic [4:0] rx_vec_count = 5'h10;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_jumper = 8'h04;
  localparam logic [7:0] reg_status = 8'h08;
  localparam logic [7:0] reg_master = 8'h0c;
  localparam logic [7:0] reg_base = 8'h10;
  localparam logic [7:0] reg_decode = 8'h14;
  localparam logic [7:0] reg_irq = 8'h18;
  localparam int ctrl_dir = 0;
  localparam int ctrl_user = 1;
  localparam int ctrl_ptimeout = 2;
  localparam int ctrl_slot1 = 3;
  localparam int ctrl_bus_tmr_en_n = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int clk_mhz = 125;
  localparam int tick_khz = 3686;
  localparam int tick_div = (clk_mhz * 1000) / tick_khz;
  localparam int timeout_ns = 50000;
  localparam int timeout_ticks = (timeout_ns * 3686) / 1000000;
  localparam int release_ns = 300;
  localparam int release_cyc = (release_ns * clk_mhz) / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    lbg_sel_none, lbg_sel_ram, lbg_sel_xram, lbg_sel_bic,
    lbg_sel_glue, lbg_sel_uart, lbg_sel_rom, lbg_sel_backplane
  } lbg_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    logic byte_wide;
    logic [23:0] addr;
  } lbg_cyc_t;

  typedef struct packed {
    logic [7:0] a16_base;
    logic priv_both;
    logic sys_ctrl;
  } lbg_jump_t;
endpackage

// ---- rtl/lbg_bus_timer.sv ----
// Purpose: Data strobe watchdog raising bus error
// Assumes: Strobe inputs already synchronised, active high
// Notes: Tick derived from ref_clk, not a second clock
`timescale 1ns/100ps
module lbg_bus_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic bus_timer_enable_n,
  output logic berr
);
  logic [7:0] div;
  logic tick;
  logic [7:0] ticks;
  logic [7:0] rel;

  // ****************************************
  // Tick generator
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst || div == 8'(lbg_pkg::tick_div - 1)) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
  assign tick = (div == 8'h00);

  // ****************************************
  // Count and bus error
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst || !strobe) begin
      ticks <= 8'h00;
    end else if (tick && ticks != 8'(lbg_pkg::timeout_ticks)) begin
      ticks <= ticks + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      berr <= 1'b0;
      rel <= 8'h00;
    end else if (strobe) begin
      rel <= 8'h00;
      if (ticks == 8'(lbg_pkg::timeout_ticks) && !bus_timer_enable_n) begin
        berr <= 1'b1;
      end
    end else if (berr) begin
      // Held past strobe negation so the master sees it end cleanly
      if (rel == 8'(lbg_pkg::release_cyc - 1)) begin
        berr <= 1'b0;
      end else begin
        rel <= rel + 8'h01;
      end
    end
  end
endmodule

// ---- rtl/lbg_top.sv ----
// Purpose: Local bus decode, boot remap, jumper path and backplane glue
// Assumes: Backplane pins and jumpers asynchronous; AHB-Lite registers
// Notes: Decode outputs registered, one cycle behind the local cycle
`timescale 1ns/100ps
module lbg_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire lbg_pkg::lbg_cyc_t cpu_cyc,
  output lbg_pkg::lbg_sel_t sel,
  output logic [23:0] ram_addr,
  input wire logic [9:0] config_jumper_field,
  output logic jumper_read_strobe_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  output logic berr_o,
  output logic berr_oe_n,
  input wire logic slot1,
  input wire logic [2:0] slave_space,
  input wire logic slave_super,
  input wire logic [23:0] slave_offset,
  input wire logic slave_req,
  input wire logic slave_block,
  output logic slave_hit,
  output logic slave_single,
  output logic [23:0] slave_ram_addr,
  output logic [2:0] bus_request,
  output logic [7:0] master_am,
  output logic [1:0] master_width,
  output logic sys_ctrl_en,
  output logic ptimeout_en,
  input wire logic [4:0] irq_source,
  input wire logic irq_valid,
  output logic [4:0] irq_vector
);
  logic [31:0] ctrl;
  logic [31:0] master_cfg;
  logic [31:0] ubuf_base;
  logic [31:0] decode_cfg;
  logic [3:0] boot_cnt;
  lbg_pkg::lbg_jump_t jumpers;
  logic jump_valid;
  logic [1:0] jump_wait;
  logic [9:0] jump_s1;
  logic [9:0] jump_s2;
  logic [1:0] ds0_s;
  logic [1:0] ds1_s;
  logic [1:0] slot_s;
  logic berr;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic [31:0] rd_mux;
  lbg_pkg::lbg_sel_t next_sel;
  logic dir_user;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ds0_s <= 2'b00;
      ds1_s <= 2'b00;
      slot_s <= 2'b00;
      jump_s1 <= 10'h000;
      jump_s2 <= 10'h000;
    end else begin
      ds0_s <= {ds0_s[0], ~ds0_n};
      ds1_s <= {ds1_s[0], ~ds1_n};
      slot_s <= {slot_s[0], slot1};
      jump_s1 <= config_jumper_field;
      jump_s2 <= jump_s1;
    end
  end

  // ****************************************
  // Jumper read path
  // ****************************************
  // Buffer enabled once after reset; jumpers feed nothing but this latch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      jumper_read_strobe_n <= 1'b1;
      jump_valid <= 1'b0;
      jump_wait <= 2'b00;
      jumpers <= '0;
    end else if (!jump_valid) begin
      jumper_read_strobe_n <= 1'b0;
      if (!jumper_read_strobe_n) begin
        jump_wait <= {jump_wait[0], 1'b1};
      end
      // Latch only once the buffered value has crossed both flip-flops
      if (jump_wait[1]) begin
        jumpers.a16_base <= jump_s2[9:2];
        jumpers.priv_both <= jump_s2[1];
        jumpers.sys_ctrl <= jump_s2[0];
        jump_valid <= 1'b1;
        jumper_read_strobe_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Boot remap
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boot_cnt <= 4'h0;
    end else if (cpu_cyc.valid && cpu_cyc.byte_wide && boot_cnt != lbg_pkg::boot_cycles) begin
      boot_cnt <= boot_cnt + 4'h1;
    end
  end

  // ****************************************
  // Local address decode
  // ****************************************
  assign dir_user = cpu_cyc.user && ctrl[lbg_pkg::ctrl_dir];
  always_comb begin
    next_sel = lbg_pkg::lbg_sel_none;
    if (!cpu_cyc.valid) begin
      next_sel = lbg_pkg::lbg_sel_none;
    end else if (dir_user) begin
      next_sel = cpu_cyc.write ? lbg_pkg::lbg_sel_ram : lbg_pkg::lbg_sel_backplane;
    end else if (boot_cnt != lbg_pkg::boot_cycles && cpu_cyc.addr <= lbg_pkg::ram_last) begin
      next_sel = lbg_pkg::lbg_sel_rom;
    end else if (cpu_cyc.addr <= lbg_pkg::ram_last) begin
      next_sel = lbg_pkg::lbg_sel_ram;
    end else if (cpu_cyc.addr <= lbg_pkg::xram_last) begin
      next_sel = lbg_pkg::lbg_sel_xram;
    end else if (cpu_cyc.addr >= lbg_pkg::bic_first && cpu_cyc.addr <= lbg_pkg::bic_last) begin
      next_sel = lbg_pkg::lbg_sel_bic;
    end else if (cpu_cyc.addr >= lbg_pkg::glue_first && cpu_cyc.addr <= lbg_pkg::glue_last) begin
      next_sel = lbg_pkg::lbg_sel_glue;
    end else if (cpu_cyc.addr >= lbg_pkg::uart_first && cpu_cyc.addr <= lbg_pkg::uart_last) begin
      next_sel = lbg_pkg::lbg_sel_uart;
    end else if (cpu_cyc.addr >= lbg_pkg::rom_first) begin
      next_sel = lbg_pkg::lbg_sel_rom;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel <= lbg_pkg::lbg_sel_none;
      ram_addr <= 24'h000000;
    end else begin
      sel <= next_sel;
      ram_addr <= cpu_cyc.addr;
    end
  end

  // ****************************************
  // Backplane slave decode
  // ****************************************
  // Space code: 0 A16, 1 A24, 2 A32
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slave_hit <= 1'b0;
      slave_single <= 1'b0;
      slave_ram_addr <= 24'h000000;
    end else begin
      slave_hit <= 1'b0;
      slave_single <= 1'b0;
      // Nonprivileged-only has no encoding: privilege bit only widens access
      if (slave_req && jump_valid && (slave_super || jumpers.priv_both)) begin
        if (slave_space == 3'h0 && slave_offset[15:8] == jumpers.a16_base) begin
          slave_hit <= 1'b1;
          slave_ram_addr <= lbg_pkg::a16_ram_first | {16'h0000, slave_offset[7:0]};
        end else if (slave_space != 3'h0 && slave_offset >= ubuf_base[23:0]
                     && (slave_offset - ubuf_base[23:0]) <= lbg_pkg::ubuf_last) begin
          slave_hit <= 1'b1;
          slave_ram_addr <= slave_offset - ubuf_base[23:0];
        end
        // Each beat is a single local cycle, block or not
        slave_single <= slave_block || 1'b1;
      end
    end
  end

  // ****************************************
  // Master and system controller
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_request <= 3'b000;
      master_am <= 8'h00;
      master_width <= 2'b00;
      sys_ctrl_en <= 1'b0;
      ptimeout_en <= 1'b0;
    end else begin
      bus_request <= 3'b000;
      if (next_sel == lbg_pkg::lbg_sel_backplane) begin
        bus_request[master_cfg[9:8] > 2'h2 ? 2'h2 : master_cfg[9:8]] <= 1'b1;
      end
      master_am <= master_cfg[7:0];
      master_width <= master_cfg[11:10];
      sys_ctrl_en <= jump_valid && jumpers.sys_ctrl;
      ptimeout_en <= jump_valid && jumpers.sys_ctrl && slot_s[1]
                     && ctrl[lbg_pkg::ctrl_ptimeout];
    end
  end

  // ****************************************
  // Interrupt vectors
  // ****************************************
  // Source 0-15 receive ready; 16-23 shared pair events
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_vector <= 5'h00;
    end else if (irq_valid) begin
      irq_vector <= (irq_source < lbg_pkg::rx_vec_count) ? irq_source
                    : (lbg_pkg::rx_vec_count | {2'b00, irq_source[2:0]});
    end
  end

  // ****************************************
  // Bus timer
  // ****************************************
  lbg_bus_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .strobe(ds0_s[1] || ds1_s[1]),
    .bus_timer_enable_n(ctrl[lbg_pkg::ctrl_bus_tmr_en_n]),
    .berr(berr)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      berr_o <= 1'b0;
      berr_oe_n <= 1'b1;
    end else begin
      berr_o <= 1'b0;
      berr_oe_n <= ~berr;
    end
  end

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= 32'h00000000;
      master_cfg <= 32'h00000000;
      ubuf_base <= 32'h00000000;
      decode_cfg <= 32'h00000000;
    end else if (ph_valid && ph_write) begin
      case (ph_addr)
        lbg_pkg::reg_ctrl: ctrl <= hwdata;
        lbg_pkg::reg_master: master_cfg <= hwdata;
        lbg_pkg::reg_base: ubuf_base <= hwdata;
        lbg_pkg::reg_decode: decode_cfg <= hwdata;
        default: ;
      endcase
    end
  end

  // Read word picked in the address phase so it stands for the data phase
  always_comb begin
    case (haddr[7:0])
      lbg_pkg::reg_ctrl: rd_mux = ctrl;
      lbg_pkg::reg_jumper: rd_mux = {21'h000000, jump_valid, jumpers};
      lbg_pkg::reg_status: rd_mux = {24'h000000, 3'b000, berr, slot_s[1],
                                     boot_cnt == lbg_pkg::boot_cycles, ds1_s[1], ds0_s[1]};
      lbg_pkg::reg_master: rd_mux = master_cfg;
      lbg_pkg::reg_base: rd_mux = ubuf_base;
      lbg_pkg::reg_decode: rd_mux = decode_cfg;
      lbg_pkg::reg_irq: rd_mux = {27'h0000000, irq_vector};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // A read pipelined right behind a write to the same word sees the old value
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule

// ---- verif/lbg_host_model.sv ----
// Purpose: Backplane master model driving the data strobes
// Assumes: Strobes pulled up, changed just after ref_clk edges
// Notes: One strobe held for len cycles after each go pulse
`timescale 1ns/100ps
module lbg_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic which,
  input wire logic [15:0] len,
  output logic ds0_n,
  output logic ds1_n,
  output logic done
);
  logic [15:0] cnt = 16'h0;
  initial begin
    ds0_n = 1'b1;
    ds1_n = 1'b1;
    done = 1'b0;
  end
  // Single access at a time, released fully between accesses
  always @(posedge ref_clk) begin
    done <= 1'b0;
    if (go) begin
      cnt <= len;
      ds0_n <= which;
      ds1_n <= !which;
    end else if (cnt == 16'h1) begin
      cnt <= 16'h0;
      ds0_n <= 1'b1;
      ds1_n <= 1'b1;
      done <= 1'b1;
    end else if (cnt != 16'h0) begin
      cnt <= cnt - 16'h1;
    end
  end
endmodule

// ---- verif/lbg_top_properties.sv ----
// Purpose: Port checker for lbg_top
// Assumes: Decode one cycle behind the local cycle
// Notes: Timer bounds kept loose against tick phase
`timescale 1ns/100ps
module lbg_top_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire lbg_pkg::lbg_cyc_t cpu_cyc,
  input wire lbg_pkg::lbg_sel_t sel,
  input wire logic jumper_read_strobe_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic berr_oe_n,
  input wire logic slave_hit,
  input wire logic [23:0] slave_ram_addr,
  input wire logic [2:0] bus_request,
  input wire logic sys_ctrl_en,
  input wire logic ptimeout_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic sup;
  logic [12:0] busy;
  logic [5:0] idle;
  assign sup = cpu_cyc.valid && !cpu_cyc.user;
  // Saturate so long runs never wrap into a false early count
  always_ff @(posedge ref_clk) begin
    if (rst || (ds0_n && ds1_n)) busy <= 13'h0;
    else if (busy != 13'h1fff) busy <= busy + 13'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !ds0_n || !ds1_n) idle <= 6'h0;
    else if (idle != 6'h3f) idle <= idle + 6'h1;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_uart_decode: assert property (sup && cpu_cyc.addr >= lbg_pkg::uart_first &&
    cpu_cyc.addr <= lbg_pkg::uart_last |=> sel == lbg_pkg::lbg_sel_uart)
    else $error("uart decode wrong");
  a_bic_decode: assert property (sup && cpu_cyc.addr >= lbg_pkg::bic_first &&
    cpu_cyc.addr <= lbg_pkg::bic_last |=> sel == lbg_pkg::lbg_sel_bic)
    else $error("controller decode wrong");
  a_glue_decode: assert property (sup && cpu_cyc.addr >= lbg_pkg::glue_first &&
    cpu_cyc.addr <= lbg_pkg::glue_last |=> sel == lbg_pkg::lbg_sel_glue)
    else $error("glue decode wrong");
  a_berr_early: assert property ($fell(berr_oe_n) |-> busy >= 13'd6000)
    else $error("bus error too early");
  a_berr_release: assert property (idle == 6'd45 |-> berr_oe_n)
    else $error("bus error held too long");
  a_jumper_strobe: assert property (!jumper_read_strobe_n |-> ##[1:3] jumper_read_strobe_n)
    else $error("jumper strobe stuck");
  a_request_level: assert property (bus_request != 3'h0 |->
    $onehot(bus_request) && sel == lbg_pkg::lbg_sel_backplane)
    else $error("bad bus request");
  a_ptimeout_gate: assert property (ptimeout_en |-> sys_ctrl_en)
    else $error("timeout without controller");
  a_private_hidden: assert property (slave_hit |-> slave_ram_addr <= lbg_pkg::ubuf_last ||
    slave_ram_addr >= lbg_pkg::a16_ram_first)
    else $error("private ram exposed");
  cover property ($fell(berr_oe_n));
  cover property (slave_hit);
  cover property (sel == lbg_pkg::lbg_sel_backplane);
endmodule
bind lbg_top lbg_top_properties u_props (.ref_clk, .rst, .hreadyout, .hresp, .cpu_cyc,
  .sel, .jumper_read_strobe_n, .ds0_n, .ds1_n, .berr_oe_n, .slave_hit, .slave_ram_addr,
  .bus_request, .sys_ctrl_en, .ptimeout_en);

// ---- verif/lbg_top_tb.sv ----
// Purpose: Self-checking bench for lbg_top
// Assumes: AHB read data taken at the edge that ends the data phase
// Notes: AHB and CPU drivers queue results, a monitor compares them
`timescale 1ns/100ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module lbg_top_tb;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ex, seed = 32'h691e53b5;
  logic [1:0] htrans = 2'h0, master_width;
  logic [2:0] hsize = 3'h2, slave_space = 3'h0, bus_request;
  logic jumper_read_strobe_n, ds0_n, ds1_n, berr_oe_n, slot1 = 1'b0, slave_super = 1'b0;
  logic slave_req = 1'b0, slave_block = 1'b0, slave_hit, slave_single, sys_ctrl_en;
  logic ptimeout_en, go = 1'b0, which = 1'b0, done, rd_seen = 1'b0, pv = 1'b0;
  logic irq_valid = 1'b0;
  logic [4:0] irq_source = 5'h0, irq_vector;
  logic [23:0] slave_offset = 24'h0, slave_ram_addr, a, ram_addr, ex_a;
  logic [23:0] ad_q[$];
  logic [7:0] master_am;
  logic [15:0] len = 16'h0;
  logic [9:0] config_jumper_field;
  logic [23:0] edg [12] = '{24'h03ffff, 24'h040000, 24'h1fffff, 24'h200000, 24'h27ffff,
    24'h280000, 24'h2fffff, 24'h300000, 24'h37ffff, 24'h380000, 24'h3fffff, 24'h03ff00};
  lbg_pkg::lbg_cyc_t cpu_cyc = '0;
  lbg_pkg::lbg_sel_t sel, ex_sel;
  logic [31:0] rd_q[$];
  lbg_pkg::lbg_sel_t sel_q[$];
  int fails = 0, check_count = 0;
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  lbg_host_model HM (.ref_clk, .go, .which, .len, .ds0_n, .ds1_n, .done);
  lbg_top DUT (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .cpu_cyc, .sel, .ram_addr, .config_jumper_field,
    .jumper_read_strobe_n, .ds0_n, .ds1_n, .berr_o(), .berr_oe_n, .slot1, .slave_space,
    .slave_super, .slave_offset, .slave_req, .slave_block, .slave_hit, .slave_single,
    .slave_ram_addr, .bus_request, .master_am, .master_width, .sys_ctrl_en, .ptimeout_en,
    .irq_source, .irq_valid, .irq_vector);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic lbg_pkg::lbg_sel_t dec(input logic [23:0] x);
    if (x <= lbg_pkg::ram_last) return lbg_pkg::lbg_sel_ram;
    if (x <= lbg_pkg::xram_last) return lbg_pkg::lbg_sel_xram;
    if (x <= lbg_pkg::bic_last) return lbg_pkg::lbg_sel_bic;
    if (x <= lbg_pkg::glue_last) return lbg_pkg::lbg_sel_glue;
    if (x <= lbg_pkg::uart_last) return lbg_pkg::lbg_sel_uart;
    return lbg_pkg::lbg_sel_rom;
  endfunction
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin fails++; close_out(); end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, ad};
    edge_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    if (!wr) begin rd_q.push_back(d); rd_seen <= 1'b1; end
    edge_rdy();
    rd_seen <= 1'b0;
  endtask
  task automatic cpu(input logic w, u, b, input logic [23:0] x, input lbg_pkg::lbg_sel_t e);
    cpu_cyc <= '{1'b1, w, u, b, x};
    sel_q.push_back(e);
    ad_q.push_back(x);
    @(posedge ref_clk);
  endtask
  task automatic slv(input logic [2:0] sp, input logic su, bk, hit, input logic [23:0] o, ra);
    int n;
    slave_space <= sp; slave_super <= su; slave_block <= bk; slave_offset <= o;
    slave_req <= 1'b1;
    @(posedge ref_clk);
    slave_req <= 1'b0;
    n = 0;
    while (slave_hit !== 1'b1 && n < 5) begin @(posedge ref_clk); n++; end
    `CHK("slave_hit", hit, slave_hit)
    if (hit) `CHK("slave_ram_addr", ra, slave_ram_addr)
    if (hit) `CHK("slave_single", 1'b1, slave_single)
  endtask
  task automatic strobe(input logic w, input logic [15:0] l, input logic exp_n);
    int n;
    which <= w; len <= l; go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 9000) begin @(posedge ref_clk); n++; end
    if (n >= 9000) begin fails++; close_out(); end
    `CHK("berr_oe_n", exp_n, berr_oe_n)
    repeat (45) @(posedge ref_clk);
    `CHK("berr_oe_n", 1'b1, berr_oe_n)
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen && hreadyout) begin
      ex = rd_q.pop_front();
      `CHK("hrdata", ex, hrdata)
    end
    if (pv) begin
      ex_sel = sel_q.pop_front();
      ex_a = ad_q.pop_front();
      `CHK("ram_addr", ex_a, ram_addr)
      `CHK("sel", ex_sel, sel)
      if (ex_sel == lbg_pkg::lbg_sel_backplane) `CHK("bus_request", 3'h2, bus_request)
    end
    pv <= cpu_cyc.valid;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    close_out();
  end
  initial begin
    config_jumper_field <= (seed[9:0] & 10'h3fc) | 10'h001;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      cpu(1'b0, 1'b0, 1'b1, 24'h0, i < 8 ? lbg_pkg::lbg_sel_rom : lbg_pkg::lbg_sel_ram);
    end
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      a = i < 12 ? edg[i] : {2'b00, seed[21:0]};
      cpu(seed[31], 1'b0, 1'b0, a, dec(a));
    end
    cpu_cyc <= '0;
    @(posedge ref_clk);
    ahb(1'b1, lbg_pkg::reg_master, 32'h0000093d);
    ahb(1'b0, lbg_pkg::reg_master, 32'h0000093d);
    `CHK("master_am", 8'h3d, master_am)
    `CHK("master_width", 2'h2, master_width)
    ahb(1'b1, lbg_pkg::reg_ctrl, 32'h1);
    ahb(1'b0, lbg_pkg::reg_ctrl, 32'h1);
    cpu(1'b0, 1'b1, 1'b0, 24'h001000, lbg_pkg::lbg_sel_backplane);
    cpu(1'b1, 1'b1, 1'b0, 24'h200000, lbg_pkg::lbg_sel_ram);
    cpu(1'b0, 1'b0, 1'b0, 24'h001000, lbg_pkg::lbg_sel_ram);
    cpu_cyc <= '0;
    @(posedge ref_clk);
    ahb(1'b1, lbg_pkg::reg_ctrl, 32'h0);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    ahb(1'b0, 8'h1c, 32'h0);
    ahb(1'b1, lbg_pkg::reg_jumper, 32'h0);
    ahb(1'b0, lbg_pkg::reg_jumper, {21'h0, 1'b1, config_jumper_field});
    `CHK("sys_ctrl_en", 1'b1, sys_ctrl_en)
    slot1 <= 1'b1;
    ahb(1'b1, lbg_pkg::reg_ctrl, 32'h4);
    repeat (6) @(posedge ref_clk);
    `CHK("ptimeout_en", 1'b1, ptimeout_en)
    slot1 <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK("ptimeout_en", 1'b0, ptimeout_en)
    slv(3'h0, 1'b1, 1'b0, 1'b1, {8'h00, config_jumper_field[9:2], 8'h10}, 24'h03ff10);
    slv(3'h0, 1'b0, 1'b0, 1'b0, {8'h00, config_jumper_field[9:2], 8'h10}, 24'h0);
    slv(3'h1, 1'b1, 1'b1, 1'b1, 24'h000100, 24'h000100);
    ahb(1'b1, lbg_pkg::reg_base, 32'h00010000);
    ahb(1'b0, lbg_pkg::reg_base, 32'h00010000);
    slv(3'h2, 1'b1, 1'b0, 1'b1, 24'h010200, 24'h000200);
    slv(3'h2, 1'b1, 1'b0, 1'b0, 24'h00ff00, 24'h0);
    slv(3'h1, 1'b1, 1'b1, 1'b0, 24'h030000, 24'h0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      irq_source <= seed[4:0];
      irq_valid <= 1'b1;
      @(posedge ref_clk);
      irq_valid <= 1'b0;
      @(posedge ref_clk);
      `CHK("irq_vector", seed[4] ? {2'b10, seed[2:0]} : seed[4:0], irq_vector)
    end
    strobe(1'b0, 16'd6200, 1'b0);
    strobe(1'b1, 16'd4000, 1'b1);
    strobe(1'b1, 16'd4000, 1'b1);
    ahb(1'b1, lbg_pkg::reg_ctrl, 32'h10);
    strobe(1'b0, 16'd6200, 1'b1);
    close_out();
  end
endmodule
